// ---- logic/rtctr_defs.svh ----
/*
  Constants of the trim and interrupt routing block: register offsets,
  field positions, reset values and timing counts.
  Assumes it is included by bare name wherever one of them is used.
*/
`ifndef RTCTR_DEFS_SVH
`define RTCTR_DEFS_SVH

// ==========================================================
// Register offsets
`define RTCTR_TRIM_ADDR       8'h24
`define RTCTR_OSC_ADDR        8'h25
`define RTCTR_EN_FIRST_ADDR   8'h29
`define RTCTR_EN_SECOND_ADDR  8'h2A
`define RTCTR_PIN_CFG_ADDR    8'h2C

// ==========================================================
// Fields and reset values
`define RTCTR_RATE_BIT        6
`define RTCTR_CORR_IE_BIT     5
`define RTCTR_FIRST_MODE_LSB  0
`define RTCTR_CAPT_FUNC_LSB   2
`define RTCTR_FIRST_MODE_IRQ  2'h2
`define RTCTR_CAPT_FUNC_IRQ   2'h1
`define RTCTR_REG_RESET       8'h00
`define RTCTR_RDATA_NONE      8'h00

// ==========================================================
// Timing
`define RTCTR_MCLK_HZ         125000000
`define RTCTR_OSC_HZ          32768
`define RTCTR_TICK_DIV        (`RTCTR_MCLK_HZ / `RTCTR_OSC_HZ)
`define RTCTR_SUBSEC_TICKS    32768
`define RTCTR_TICK128_DIV     256
`define RTCTR_SEC_PER_MIN     60
`define RTCTR_MIN_PER_HOUR    60
`define RTCTR_SLOW_HOURS      4
`define RTCTR_FAST_MINUTES    8
`define RTCTR_STEP_SLOW_PPM   2.170
`define RTCTR_STEP_FAST_PPM   2.0345

`endif

// ---- logic/rtctr_pkg.sv ----
/*
  Types of the trim and interrupt routing block.
  Assumes nothing of its surroundings.
*/
package rtctr_pkg;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_RUN  = 2'b10
  } rtctr_corr_state_t;

  // Settings sampled at each correction trigger
  typedef struct packed {
    logic       fast;
    logic [7:0] trim;
  } rtctr_corr_cfg_t;

endpackage

// ---- logic/rtctr_irq_pulse.sv ----
/*
  One pulse-mode interrupt stretcher: set by an enabled event, released
  by the second 128 Hz tick that follows.
  Assumes the tick is an enable pulse on the same clock, free-running and
  unrelated to the events.
*/
`timescale 1ns/1ps
`default_nettype none

module rtctr_irq_pulse (
  input  wire logic mclk_i,     // System clock
  input  wire logic rst_n_i,    // Async reset, active low
  input  wire logic trig_i,     // Event, one cycle
  input  wire logic enable_i,   // Event passes to this output
  input  wire logic tick128_i,  // 128 Hz enable pulse
  output logic      active_o    // Interrupt asserted, active high
);

  logic seen;
  logic next_active;
  logic next_seen;

  // ==========================================================
  // Pulse stretcher
  always_comb begin
    next_active = active_o;
    next_seen   = seen;
    if (trig_i && enable_i) begin
      next_active = 1'b1;
      next_seen   = 1'b0;
    end else if (active_o && tick128_i) begin
      // First tick may be close; second guarantees a full period
      next_active = !seen;
      next_seen   = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_o <= 1'b0;
      seen     <= 1'b0;
    end else begin
      active_o <= next_active;
      seen     <= next_seen;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_second_tick;
    active_o && seen && tick128_i && !(trig_i && enable_i);
  endsequence

  pulse_start_a: assert property (
    trig_i && enable_i |=> active_o && !seen)
    else $error("enabled event did not assert interrupt");
  pulse_gate_a: assert property (
    !active_o && !(trig_i && enable_i) |=> !active_o)
    else $error("interrupt asserted without enabled event");
  pulse_end_a: assert property (
    s_second_tick |=> !active_o)
    else $error("interrupt not released at second tick");
  pulse_hold_a: assert property (
    active_o && !tick128_i |=> active_o)
    else $error("interrupt released between ticks");

endmodule

`default_nettype wire

// ---- logic/rtctr_top.sv ----
/*
  Clock trim engine with correction interrupts routed to two pins.
  Holds a seconds time base, the trim, rate, enable and pin registers,
  and the correction sequencer.
  Assumes a byte register port decoded upstream and a 125 MHz clock.
*/
// Notes on behaviour
// - Rate 0: correction every four hours
// - Rate 1: correction every eight minutes
// - Trim is two's complement, zero means none
// - Trim by adding or removing prescaler counts
// - Slow mode: one pulse per minute, magnitude
// - Slow pulses from minute 00, spill onward
// - Fast mode: one pulse per second, magnitude
// - Fast pulses from second 00, spill onward
// - Each correction may pulse either output
// - No correction flag, pulses only
// - Two outputs, own enable registers
// - First output open-drain, pin mode gated
// - Second output push-pull on capture pin
// - Drive only in interrupt mode, active low
// - Trim register at 24h
// - Enable is bit 5, default off
// - Pulse released by 128 Hz, 1-2 periods
`include "rtctr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtctr_top #(
  parameter int SUBSEC_TICKS = `RTCTR_SUBSEC_TICKS,
  parameter int TICK_DIV     = `RTCTR_TICK_DIV
) (
  input  wire logic       mclk_i,             // System clock
  input  wire logic       rst_n_i,            // Async reset, active low
  input  wire logic [7:0] reg_addr_i,         // Register offset
  input  wire logic [7:0] reg_wdata_i,        // Write data
  input  wire logic       reg_wr_i,           // Write strobe
  input  wire logic       reg_rd_i,           // Read strobe
  output logic      [7:0] reg_rdata_o,        // Read data
  output logic            irq_first_o,        // First pin level
  output logic            irq_first_oe_n_o,   // First pin drive, low
  output logic            capture_pin_o,      // Capture pin level
  output logic            capture_pin_oe_n_o, // Capture pin drive, low
  output logic            corr_pulse_o        // Correction made
);

  localparam logic [11:0] TICK_LAST = 12'(TICK_DIV - 1);
  localparam logic [15:0] SUB_TICKS = 16'(SUBSEC_TICKS);

  // ==========================================================
  // Register file
  logic [7:0] trim_value_reg;
  logic [7:0] oscillator_control;
  logic [7:0] first_irq_enable_reg;
  logic [7:0] second_irq_enable_reg;
  logic [7:0] pin_cfg;
  logic [7:0] next_trim, next_osc, next_en_a, next_en_b, next_pin;
  logic [7:0] next_rdata;

  always_comb begin
    next_trim  = trim_value_reg;
    next_osc   = oscillator_control;
    next_en_a  = first_irq_enable_reg;
    next_en_b  = second_irq_enable_reg;
    next_pin   = pin_cfg;
    next_rdata = reg_rdata_o;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `RTCTR_TRIM_ADDR:      next_trim = reg_wdata_i;
        `RTCTR_OSC_ADDR:       next_osc  = reg_wdata_i;
        `RTCTR_EN_FIRST_ADDR:  next_en_a = reg_wdata_i;
        `RTCTR_EN_SECOND_ADDR: next_en_b = reg_wdata_i;
        `RTCTR_PIN_CFG_ADDR:   next_pin  = reg_wdata_i;
        default:               next_pin  = pin_cfg;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `RTCTR_TRIM_ADDR:      next_rdata = trim_value_reg;
        `RTCTR_OSC_ADDR:       next_rdata = oscillator_control;
        `RTCTR_EN_FIRST_ADDR:  next_rdata = first_irq_enable_reg;
        `RTCTR_EN_SECOND_ADDR: next_rdata = second_irq_enable_reg;
        `RTCTR_PIN_CFG_ADDR:   next_rdata = pin_cfg;
        default:               next_rdata = `RTCTR_RDATA_NONE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_value_reg        <= `RTCTR_REG_RESET;
      oscillator_control    <= `RTCTR_REG_RESET;
      first_irq_enable_reg  <= `RTCTR_REG_RESET;
      second_irq_enable_reg <= `RTCTR_REG_RESET;
      pin_cfg               <= `RTCTR_REG_RESET;
      reg_rdata_o           <= `RTCTR_RDATA_NONE;
    end else begin
      trim_value_reg        <= next_trim;
      oscillator_control    <= next_osc;
      first_irq_enable_reg  <= next_en_a;
      second_irq_enable_reg <= next_en_b;
      pin_cfg               <= next_pin;
      reg_rdata_o           <= next_rdata;
    end
  end

  logic       rate_fast;
  logic [1:0] first_mode, capt_func;
  assign rate_fast  = oscillator_control[`RTCTR_RATE_BIT];
  assign first_mode = pin_cfg[`RTCTR_FIRST_MODE_LSB +: 2];
  assign capt_func  = pin_cfg[`RTCTR_CAPT_FUNC_LSB +: 2];

  // ==========================================================
  // Time base and correction sequencer
  logic [11:0] div_cnt, next_div_cnt;
  logic [7:0]  t128_cnt, next_t128_cnt;
  logic [15:0] subsec, next_subsec;
  logic [5:0]  sec, next_sec, mins, next_mins;
  logic [1:0]  hr4, next_hr4;
  logic [2:0]  min8, next_min8;
  logic        adj_pos, next_adj_pos, adj_neg, next_adj_neg;
  logic [7:0]  rem, next_rem;
  logic        next_corr;
  rtctr_pkg::rtctr_corr_state_t state, next_state;
  rtctr_pkg::rtctr_corr_cfg_t   cfg, next_cfg;

  logic        tick32, tick128, sec_tick, min_tick, hr_tick;
  logic        trig, unit_tick, fire;
  logic [7:0]  mag;
  logic [16:0] sum;
  logic [1:0]  step;

  always_comb begin
    tick32   = (div_cnt == TICK_LAST);
    tick128  = tick32 && (t128_cnt == 8'(`RTCTR_TICK128_DIV - 1));
    // Positive trim skips a count, negative holds one
    step     = adj_pos ? 2'h2 : (adj_neg ? 2'h0 : 2'h1);
    sum      = {1'b0, subsec} + {15'h0000, step};
    sec_tick = tick32 && (sum >= {1'b0, SUB_TICKS});
    min_tick = sec_tick && (sec == 6'(`RTCTR_SEC_PER_MIN - 1));
    hr_tick  = min_tick && (mins == 6'(`RTCTR_MIN_PER_HOUR - 1));
    trig     = rate_fast ?
               (min_tick && (min8 == 3'(`RTCTR_FAST_MINUTES - 1))) :
               (hr_tick && (hr4 == 2'(`RTCTR_SLOW_HOURS - 1)));
    unit_tick = cfg.fast ? sec_tick : min_tick;
    mag = trim_value_reg[7] ? 8'(~trim_value_reg + 8'h01)
                            : trim_value_reg;

    next_div_cnt  = tick32 ? 12'h000 : 12'(div_cnt + 12'h001);
    next_t128_cnt = tick32 ? 8'(t128_cnt + 8'h01) : t128_cnt;
    next_subsec   = subsec;
    next_sec      = sec;
    next_mins     = mins;
    next_hr4      = hr4;
    next_min8     = min8;
    next_adj_pos  = adj_pos;
    next_adj_neg  = adj_neg;
    if (tick32) begin
      next_adj_pos = 1'b0;
      next_adj_neg = 1'b0;
      next_subsec  = sec_tick ? 16'(sum - {1'b0, SUB_TICKS})
                              : sum[15:0];
    end
    if (sec_tick) begin
      next_sec = min_tick ? 6'h00 : 6'(sec + 6'h01);
    end
    if (min_tick) begin
      next_mins = hr_tick ? 6'h00 : 6'(mins + 6'h01);
      next_min8 = 3'(min8 + 3'h1);
    end
    if (hr_tick) begin
      next_hr4 = 2'(hr4 + 2'h1);
    end

    fire       = 1'b0;
    next_rem   = rem;
    next_state = state;
    next_cfg   = cfg;
    if (trig) begin
      // New trim and pulse unit only take hold here; the trigger period follows the rate bit at once
      next_cfg = '{fast: rate_fast, trim: trim_value_reg};
      fire     = (mag != 8'h00);
      next_rem = fire ? 8'(mag - 8'h01) : 8'h00;
      next_state = (mag > 8'h01) ? rtctr_pkg::CS_RUN
                                 : rtctr_pkg::CS_IDLE;
    end else begin
      case (state)
        rtctr_pkg::CS_RUN: begin
          if (unit_tick) begin
            fire     = 1'b1;
            next_rem = 8'(rem - 8'h01);
            if (rem == 8'h01) begin
              next_state = rtctr_pkg::CS_IDLE;
            end
          end
        end
        rtctr_pkg::CS_IDLE: next_state = rtctr_pkg::CS_IDLE;
        default:            next_state = rtctr_pkg::CS_IDLE;
      endcase
    end
    if (fire) begin
      next_adj_pos = !next_cfg.trim[7];
      next_adj_neg = next_cfg.trim[7];
    end
    next_corr = fire;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt      <= 12'h000;
      t128_cnt     <= 8'h00;
      subsec       <= 16'h0000;
      sec          <= 6'h00;
      mins         <= 6'h00;
      hr4          <= 2'h0;
      min8         <= 3'h0;
      adj_pos      <= 1'b0;
      adj_neg      <= 1'b0;
      rem          <= 8'h00;
      state        <= rtctr_pkg::CS_IDLE;
      cfg          <= '0;
      corr_pulse_o <= 1'b0;
    end else begin
      div_cnt      <= next_div_cnt;
      t128_cnt     <= next_t128_cnt;
      subsec       <= next_subsec;
      sec          <= next_sec;
      mins         <= next_mins;
      hr4          <= next_hr4;
      min8         <= next_min8;
      adj_pos      <= next_adj_pos;
      adj_neg      <= next_adj_neg;
      rem          <= next_rem;
      state        <= next_state;
      cfg          <= next_cfg;
      corr_pulse_o <= next_corr;
    end
  end

  // ==========================================================
  // Interrupt routing
  logic act_first, act_second;

  rtctr_irq_pulse u_irq_first (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .trig_i    (fire),
    .enable_i  (first_irq_enable_reg[`RTCTR_CORR_IE_BIT]),
    .tick128_i (tick128),
    .active_o  (act_first)
  );

  rtctr_irq_pulse u_irq_second (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .trig_i    (fire),
    .enable_i  (second_irq_enable_reg[`RTCTR_CORR_IE_BIT]),
    .tick128_i (tick128),
    .active_o  (act_second)
  );

  logic first_on, second_on;
  logic next_first_oe_n, next_capt, next_capt_oe_n;

  always_comb begin
    first_on  = (first_mode == `RTCTR_FIRST_MODE_IRQ);
    second_on = (capt_func == `RTCTR_CAPT_FUNC_IRQ);
    // Open drain: only ever pulls low
    next_first_oe_n = !(first_on && act_first);
    next_capt       = !act_second;
    next_capt_oe_n  = !second_on;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_first_o        <= 1'b0;
      irq_first_oe_n_o   <= 1'b1;
      capture_pin_o      <= 1'b1;
      capture_pin_oe_n_o <= 1'b1;
    end else begin
      irq_first_o        <= 1'b0;
      irq_first_oe_n_o   <= next_first_oe_n;
      capture_pin_o      <= next_capt;
      capture_pin_oe_n_o <= next_capt_oe_n;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  trig_period_a: assert property (
    trig |=> sec == 6'h00 && (cfg.fast ? min8 == 3'h0
                                       : (mins == 6'h00 && hr4 == 2'h0)))
    else $error("correction trigger at wrong boundary");
  slow_unit_a: assert property (
    fire && !next_cfg.fast |-> min_tick)
    else $error("slow correction off minute boundary");
  fast_unit_a: assert property (
    fire && next_cfg.fast |-> sec_tick)
    else $error("fast correction off second boundary");
  zero_trim_a: assert property (
    trig && trim_value_reg == 8'h00 |=> state == rtctr_pkg::CS_IDLE
      && !corr_pulse_o)
    else $error("zero trim produced a correction");
  sample_trim_a: assert property (
    trig |=> cfg.trim == $past(trim_value_reg)
      && rem == (($past(mag) == 8'h00) ? 8'h00 : 8'($past(mag) - 8'h01)))
    else $error("trim not sampled at trigger");
  adjust_step_a: assert property (
    fire && !next_cfg.trim[7] |=> adj_pos && !adj_neg)
    else $error("positive trim did not add a count");
  od_drive_a: assert property (
    first_mode != `RTCTR_FIRST_MODE_IRQ |=> irq_first_oe_n_o
      && !irq_first_o)
    else $error("first pin driven outside interrupt mode");
  pp_drive_a: assert property (
    capt_func == `RTCTR_CAPT_FUNC_IRQ && act_second
      |=> !capture_pin_oe_n_o && !capture_pin_o)
    else $error("capture pin not driving active low");

endmodule

`default_nettype wire

// ---- test/rtctr_host_model.sv ----
/*
  Host side of the interrupt wiring: pull-up on the open-drain line and
  the receiver of the push-pull capture pin.
  Assumes the pin levels and drive enables of the trim block.
*/
`timescale 1ns/1ps
`default_nettype none

module rtctr_host_model (
  input  wire logic irq_first_i,      // First pin level from device
  input  wire logic irq_first_oe_n_i, // First pin drive, low
  input  wire logic capture_pin_i,    // Capture pin level
  input  wire logic capture_oe_n_i,   // Capture pin drive, low
  output logic      line_first_o,     // Resolved first line
  output logic      line_second_o     // Resolved capture line
);
  // ==========================================================
  // Line resolution
  logic last_capture;

  initial begin
    last_capture = 1'b0;
  end

  always @(capture_pin_i or capture_oe_n_i) begin
    if (capture_oe_n_i == 1'b0) begin
      last_capture = capture_pin_i;
    end
  end

  // Pull-up holds the shared line high when released
  assign line_first_o  = (irq_first_oe_n_i == 1'b0) ? irq_first_i : 1'b1;
  // Floating pin shows the inverse, so a stale level is never trusted
  assign line_second_o = (capture_oe_n_i == 1'b0) ? capture_pin_i
                                                  : ~last_capture;
endmodule

`default_nettype wire

// ---- test/tb_rtctr_top.sv ----
/*
  Self-checking bench of the trim block: registers, one fast-rate
  correction run at the largest magnitude, one positive correction,
  and interrupt routing.
  Assumes the block and the host model; tick divider and seconds are
  shortened by parameter, so eight minutes cost a few thousand cycles.
*/
`include "rtctr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_rtctr_top;
  // ==========================================================
  // Signals
  localparam int         TICK   = 4;
  localparam int         SUBSEC = 2;
  localparam int         T128   = 256 * TICK;
  // Held count makes each second of a negative run one tick longer
  localparam int         GAP    = (SUBSEC + 1) * TICK;
  localparam logic [7:0] ADDRS [5] = '{`RTCTR_TRIM_ADDR, `RTCTR_OSC_ADDR,
    `RTCTR_EN_FIRST_ADDR, `RTCTR_EN_SECOND_ADDR, `RTCTR_PIN_CFG_ADDR};

  logic       mclk_i;
  logic       rst_n_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic [7:0] rd;
  logic       irq_first_o;
  logic       irq_first_oe_n_o;
  logic       capture_pin_o;
  logic       capture_pin_oe_n_o;
  logic       corr_pulse_o;
  logic       line_a;
  logic       line_b;
  int         n_fail;
  int         checks_done;
  int         n_corr;
  int         i;
  longint     cyc;
  longint     last_corr;

  rtctr_top #(.SUBSEC_TICKS(SUBSEC), .TICK_DIV(TICK)) u_rtctr_top (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_first_o(irq_first_o),
    .irq_first_oe_n_o(irq_first_oe_n_o), .capture_pin_o(capture_pin_o),
    .capture_pin_oe_n_o(capture_pin_oe_n_o), .corr_pulse_o(corr_pulse_o));

  rtctr_host_model u_rtctr_host_model (
    .irq_first_i(irq_first_o), .irq_first_oe_n_i(irq_first_oe_n_o),
    .capture_pin_i(capture_pin_o), .capture_oe_n_i(capture_pin_oe_n_o),
    .line_first_o(line_a), .line_second_o(line_b));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // ==========================================================
  // Compare and access tasks
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input longint v, input longint lo, input longint hi);
    checks_done++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h..%0h", $time, v, lo, hi);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d        = reg_rdata_o;
  endtask

  task automatic wait_corr(input int n, input int lim);
    for (int k = 0; k < lim && n_corr < n; k++) begin
      @(negedge mclk_i);
    end
    chk_span(n_corr, n, n);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, n_fail);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Correction monitor: one pulse per second while a run lasts
  always @(negedge mclk_i) begin
    cyc = cyc + 1;
    if (corr_pulse_o === 1'b1) begin
      if (n_corr > 0 && n_corr < 128) begin
        chk_span(cyc - last_corr, GAP, GAP);
      end
      last_corr = cyc;
      n_corr++;
    end
  end

  initial begin
    repeat (3 * 8 * 60 * SUBSEC * TICK) @(posedge mclk_i);
    n_fail++;
    $display("[FAIL] t=%0t watchdog got=%0h exp=%0h", $time, n_corr, 128);
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    rst_n_i     = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    n_fail      = 0;
    checks_done = 0;
    n_corr      = 0;
    cyc         = 0;
    last_corr   = 0;
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    for (i = 0; i < 5; i++) begin
      reg_read(ADDRS[i], rd);
      chk_reg(rd, `RTCTR_REG_RESET);
    end
    chk_bit(irq_first_oe_n_o, 1'b1);
    chk_bit(capture_pin_oe_n_o, 1'b1);
    end_test("reset");

    for (i = 0; i < 5; i++) begin
      reg_write(ADDRS[i], 8'hA5 ^ i[7:0]);
    end
    reg_write(8'h31, 8'h5A);
    for (i = 0; i < 5; i++) begin
      reg_read(ADDRS[i], rd);
      chk_reg(rd, 8'hA5 ^ i[7:0]);
    end
    reg_read(8'h31, rd);
    chk_reg(rd, `RTCTR_RDATA_NONE);
    end_test("registers");

    // Largest magnitude in fast rate, only the first pin enabled
    reg_write(`RTCTR_TRIM_ADDR, 8'h80);
    reg_write(`RTCTR_OSC_ADDR, 8'h40);
    reg_write(`RTCTR_EN_FIRST_ADDR, 8'h20);
    reg_write(`RTCTR_EN_SECOND_ADDR, 8'h00);
    reg_write(`RTCTR_PIN_CFG_ADDR, 8'h06);
    repeat (3) @(negedge mclk_i);
    chk_bit(capture_pin_oe_n_o, 1'b0);
    chk_bit(line_b, 1'b1);
    chk_bit(line_a, 1'b1);
    wait_corr(1, 8 * 60 * SUBSEC * TICK + 200);
    repeat (3) @(negedge mclk_i);
    chk_bit(line_a, 1'b0);
    chk_bit(line_b, 1'b1);
    reg_write(`RTCTR_TRIM_ADDR, 8'h01);
    reg_write(`RTCTR_EN_SECOND_ADDR, 8'h20);
    wait_corr(2, 20000);
    repeat (3) @(negedge mclk_i);
    chk_bit(line_b, 1'b0);
    reg_write(`RTCTR_PIN_CFG_ADDR, 8'h00);
    repeat (3) @(negedge mclk_i);
    chk_bit(irq_first_oe_n_o, 1'b1);
    chk_bit(capture_pin_oe_n_o, 1'b1);
    reg_write(`RTCTR_PIN_CFG_ADDR, 8'h06);
    repeat (3) @(negedge mclk_i);
    chk_bit(line_a, 1'b0);
    wait_corr(128, 130 * 4 * TICK);
    end_test("fast run");

    // No further pulse once the magnitude is spent
    repeat (5 * 3 * TICK) @(negedge mclk_i);
    chk_span(n_corr, 128, 128);
    for (i = 0; i < 2 * T128 + 100 && line_a !== 1'b1; i++) begin
      @(negedge mclk_i);
    end
    chk_span(cyc - last_corr, T128 - 2, 2 * T128 + 4);
    chk_bit(line_b, 1'b1);
    end_test("release");

    // Trim written mid-run holds from the next trigger: one positive pulse
    wait_corr(129, 8 * 60 * SUBSEC * TICK + 200);
    repeat (4 * SUBSEC * TICK) @(negedge mclk_i);
    chk_span(n_corr, 129, 129);
    chk_bit(line_a, 1'b0);
    end_test("positive");
    complete_run();
  end
endmodule

`default_nettype wire
